//--- hw/console_power_interlock.sv
/*
  Console power interlock: standby supply latch, heater and main supply
  interlocks with their indicator lamps, warm-up timer and a small register
  port with sticky events and a masked interrupt.
  Assumes all inputs are synchronous to ref_clk and that pushbuttons are
  already debounced; switch and button inputs are active high.
*/
`timescale 1ns/1ps

// How it works
// - Standby switch up turns standby supply on and lights the standby neon.
// - Switch at centre keeps the standby relay latched, supply stays on.
// - Standby switch down turns standby supply and neon off.
// - Standby neon dark when standby supply off or a tank overheats.
// - Orange control lamp lit exactly while control power is present.
// - Heater-on press ignored unless the orange lamp is lit.
// - Accepted heater-on press turns heater power and green lamp on.
// - Yellow ready lamp lights after heater power stays on for five minutes.
// - Main-on press ignored unless key lock is on and ready lamp lit.
// - Accepted main-on press turns main supply and red lamp on.
// - Heater-off removes heater power, green lamp, main supply and red lamp.
// - Main-off removes only main supply and red lamp.
module console_power_interlock #(
  parameter int unsigned TICK_CYCLES = console_power_pkg::TICK_CYCLES,
  parameter int unsigned WARM_TICKS  = console_power_pkg::WARM_TICKS
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        standby_switch_up,
  input  wire logic        standby_switch_down,
  input  wire logic        tank_overheat,
  input  wire logic        control_power_present,
  input  wire logic        key_lock_on,
  input  wire logic        heat_enable_button,
  input  wire logic        heat_disable_button,
  input  wire logic        main_enable_button,
  input  wire logic        main_disable_button,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  output logic             standby_hold_relay,
  output logic             standby_neon,
  output logic             control_lamp,
  output logic             heat_power_on,
  output logic             heat_lamp,
  output logic             ready_lamp,
  output logic             main_supply_on,
  output logic             main_lamp
);

  localparam int unsigned TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int unsigned WARM_W = $clog2(WARM_TICKS + 1);
  localparam int unsigned EV_W   = console_power_pkg::EV_W;
  localparam int unsigned ST_W   = console_power_pkg::ST_W;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [WARM_W-1:0] WARM_DONE = WARM_W'(WARM_TICKS);

  if (TICK_CYCLES < 1 || WARM_TICKS < 1 || WARM_W > 32) begin : g_bad_params
    $error("TICK_CYCLES and WARM_TICKS must be at least 1 and fit 32 bits");
  end

  typedef struct packed {
    logic              standby;
    logic              neon;
    logic              control;
    logic              heat;
    logic              heat_lamp;
    logic              ready;
    logic              main;
    logic              main_lamp;
    logic              heat_en_prev;
    logic              heat_dis_prev;
    logic              main_en_prev;
    logic              main_dis_prev;
    logic              overheat_prev;
    logic [TICK_W-1:0] tick_cnt;
    logic [WARM_W-1:0] warm_cnt;
    logic [EV_W-1:0]   events;
    logic [EV_W-1:0]   mask;
    logic              irq;
    logic [31:0]       rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Buttons act on the press, so a button held while its interlock opens
  // does nothing until it is pressed again.
  logic heat_en_press;
  logic heat_dis_press;
  logic main_en_press;
  logic main_dis_press;
  logic [EV_W-1:0] ev_now;
  logic [ST_W-1:0] state_word;

  assign heat_en_press  = heat_enable_button  & ~st_q.heat_en_prev;
  assign heat_dis_press = heat_disable_button & ~st_q.heat_dis_prev;
  assign main_en_press  = main_enable_button  & ~st_q.main_en_prev;
  assign main_dis_press = main_disable_button & ~st_q.main_dis_prev;

  always_comb begin
    st_d = st_q;
    ev_now = '0;

    st_d.heat_en_prev  = heat_enable_button;
    st_d.heat_dis_prev = heat_disable_button;
    st_d.main_en_prev  = main_enable_button;
    st_d.main_dis_prev = main_disable_button;
    st_d.overheat_prev = tank_overheat;

    // The locking down position dominates, so a stuck up contact cannot
    // hold the supply on against the off position.
    if (standby_switch_down) begin
      st_d.standby = 1'b0;
    end else if (standby_switch_up) begin
      st_d.standby = 1'b1;
    end else begin
      st_d.standby = st_q.standby;
    end
    st_d.neon = st_d.standby & ~tank_overheat;

    st_d.control = control_power_present;

    // Heater-off wins over a simultaneous heater-on.
    if (heat_dis_press) begin
      st_d.heat = 1'b0;
    end else if (heat_en_press && st_q.control) begin
      st_d.heat = 1'b1;
    end
    st_d.heat_lamp = st_d.heat;

    // The timer runs only while heater power is on and restarts from zero.
    // Counting starts the cycle after heater power comes on, so the lamp waits the full interval.
    if (!st_d.heat) begin
      st_d.tick_cnt = '0;
      st_d.warm_cnt = '0;
    end else if (st_q.heat && st_q.warm_cnt != WARM_DONE) begin
      if (st_q.tick_cnt == TICK_LAST) begin
        st_d.tick_cnt = '0;
        st_d.warm_cnt = st_q.warm_cnt + WARM_W'(1);
      end else begin
        st_d.tick_cnt = st_q.tick_cnt + TICK_W'(1);
      end
    end
    st_d.ready = st_d.heat && (st_d.warm_cnt == WARM_DONE);

    if (heat_dis_press || main_dis_press || !st_d.heat) begin
      st_d.main = 1'b0;
    end else if (main_en_press && key_lock_on && st_q.ready) begin
      st_d.main = 1'b1;
    end
    st_d.main_lamp = st_d.main;

    ev_now[console_power_pkg::EV_STANDBY_ON]  = st_d.standby & ~st_q.standby;
    ev_now[console_power_pkg::EV_STANDBY_OFF] = ~st_d.standby & st_q.standby;
    ev_now[console_power_pkg::EV_HEAT_ON]     = st_d.heat & ~st_q.heat;
    ev_now[console_power_pkg::EV_HEAT_OFF]    = ~st_d.heat & st_q.heat;
    ev_now[console_power_pkg::EV_READY]       = st_d.ready & ~st_q.ready;
    ev_now[console_power_pkg::EV_MAIN_ON]     = st_d.main & ~st_q.main;
    ev_now[console_power_pkg::EV_MAIN_OFF]    = ~st_d.main & st_q.main;
    ev_now[console_power_pkg::EV_OVERHEAT]    = tank_overheat & ~st_q.overheat_prev;

    // A read clears the events it returns; an event in the same cycle survives.
    st_d.events = st_q.events;
    if (reg_rd && reg_addr == console_power_pkg::REG_EVENTS) begin
      st_d.events = '0;
    end
    st_d.events = st_d.events | ev_now;

    if (reg_wr && reg_addr == console_power_pkg::REG_MASK) begin
      st_d.mask = reg_wdata[EV_W-1:0];
    end

    st_d.irq = |(st_d.events & st_d.mask);

    st_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        console_power_pkg::REG_EVENTS: st_d.rdata = {{(32-EV_W){1'b0}}, st_q.events};
        console_power_pkg::REG_MASK:   st_d.rdata = {{(32-EV_W){1'b0}}, st_q.mask};
        console_power_pkg::REG_STATE:  st_d.rdata = {{(32-ST_W){1'b0}}, state_word};
        console_power_pkg::REG_WARM:   st_d.rdata = 32'(st_q.warm_cnt);
        default:                       st_d.rdata = '0;
      endcase
    end
  end

  always_comb begin
    state_word = '0;
    state_word[console_power_pkg::ST_STANDBY] = st_q.standby;
    state_word[console_power_pkg::ST_NEON]    = st_q.neon;
    state_word[console_power_pkg::ST_CONTROL] = st_q.control;
    state_word[console_power_pkg::ST_HEAT]    = st_q.heat;
    state_word[console_power_pkg::ST_READY]   = st_q.ready;
    state_word[console_power_pkg::ST_MAIN]    = st_q.main;
    state_word[console_power_pkg::ST_KEY]     = key_lock_on;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= '0;
      st_q.mask  <= console_power_pkg::MASK_RESET;
      st_q.rdata <= console_power_pkg::RDATA_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata          = st_q.rdata;
  assign irq                = st_q.irq;
  assign standby_hold_relay = st_q.standby;
  assign standby_neon       = st_q.neon;
  assign control_lamp       = st_q.control;
  assign heat_power_on      = st_q.heat;
  assign heat_lamp          = st_q.heat_lamp;
  assign ready_lamp         = st_q.ready;
  assign main_supply_on     = st_q.main;
  assign main_lamp          = st_q.main_lamp;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_heat_accept;
    heat_en_press && control_lamp && !heat_dis_press;
  endsequence

  sequence s_heat_drop;
    heat_dis_press ##1 (!heat_power_on && !heat_lamp && !main_supply_on && !main_lamp);
  endsequence

  sequence s_main_accept;
    main_en_press && key_lock_on && ready_lamp && !main_dis_press && !heat_dis_press;
  endsequence

  a_standby_on: assert property (
    standby_switch_up && !standby_switch_down |=> standby_hold_relay
  ) else $error("standby supply did not come on");

  a_standby_hold: assert property (
    !standby_switch_up && !standby_switch_down |=> $stable(standby_hold_relay)
  ) else $error("standby relay did not hold");

  a_standby_off: assert property (
    standby_switch_down |=> !standby_hold_relay && !standby_neon
  ) else $error("standby supply not off");

  a_neon_follows: assert property (
    ##1 standby_neon == ($past(standby_switch_up || standby_switch_down) ?
      ($past(standby_switch_up) && !$past(standby_switch_down) && !$past(tank_overheat))
      : ($past(standby_hold_relay) && !$past(tank_overheat)))
  ) else $error("standby neon wrong");

  a_control_lamp: assert property (
    ##1 control_lamp == $past(control_power_present)
  ) else $error("control lamp does not track control power");

  a_heat_gate: assert property (
    heat_en_press && !control_lamp && !heat_power_on |=> !heat_power_on
  ) else $error("heater-on accepted without control power");

  a_heat_on: assert property (
    s_heat_accept |=> heat_power_on && heat_lamp
  ) else $error("heater power did not come on");

  a_ready_timing: assert property (
    $rose(ready_lamp) |-> heat_power_on && (st_q.warm_cnt == WARM_DONE)
      && $past(st_q.warm_cnt) == WARM_DONE - WARM_W'(1)
  ) else $error("ready lamp lit before the warm-up count");

  a_main_gate: assert property (
    main_en_press && !(key_lock_on && ready_lamp) && !main_supply_on |=> !main_supply_on
  ) else $error("main supply accepted without key and ready");

  a_main_on: assert property (
    s_main_accept |=> main_supply_on && main_lamp
  ) else $error("main supply did not come on");

  a_heat_off: assert property (
    heat_dis_press |-> s_heat_drop
  ) else $error("heater-off left power on");

  a_main_off_only: assert property (
    main_dis_press && !heat_dis_press && !heat_en_press && heat_power_on
      |=> !main_supply_on && !main_lamp && heat_power_on && heat_lamp
  ) else $error("main-off disturbed heater power");

  a_warm_clear: assert property (
    !heat_power_on |-> !ready_lamp && st_q.warm_cnt == '0 && st_q.tick_cnt == '0
  ) else $error("warm-up timer not cleared with heater off");

  a_irq_level: assert property (
    ##1 irq == |(st_q.events & st_q.mask)
  ) else $error("interrupt does not match masked events");

  // The warm-up count only moves while heater power stays on.
  sequence s_warm_running;
    heat_power_on && !heat_dis_press && st_q.warm_cnt != WARM_DONE;
  endsequence

  a_warm_start: assert property (
    $rose(heat_power_on) |-> st_q.warm_cnt == '0 && st_q.tick_cnt == '0
  ) else $error("warm-up count did not start from zero");

  a_tick_step: assert property (
    s_warm_running |=> st_q.tick_cnt ==
      (($past(st_q.tick_cnt) == TICK_LAST) ? '0 : $past(st_q.tick_cnt) + TICK_W'(1))
  ) else $error("tick counter skipped");

  a_warm_step: assert property (
    s_warm_running ##0 st_q.tick_cnt == TICK_LAST
      |=> st_q.warm_cnt == $past(st_q.warm_cnt) + WARM_W'(1)
  ) else $error("warm-up count did not advance");

  a_warm_hold: assert property (
    heat_power_on && !heat_dis_press && st_q.warm_cnt == WARM_DONE
      |=> ready_lamp && st_q.warm_cnt == WARM_DONE
  ) else $error("ready lamp dropped while heater power stayed on");

  a_main_needs_ready: assert property (
    main_supply_on |-> heat_power_on && ready_lamp
  ) else $error("main supply on without heater power and ready lamp");

  a_lamps_follow: assert property (
    heat_lamp == heat_power_on && main_lamp == main_supply_on
  ) else $error("lamp differs from its supply");

  a_events_read: assert property (
    reg_rd && reg_addr == console_power_pkg::REG_EVENTS
      |=> reg_rdata == 32'($past(st_q.events)) && st_q.events == $past(ev_now)
  ) else $error("event read did not return and clear the events");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == '0
  ) else $error("read data not zero outside a read");

  a_mask_write: assert property (
    reg_wr && reg_addr == console_power_pkg::REG_MASK
      |=> st_q.mask == $past(reg_wdata[EV_W-1:0])
  ) else $error("mask write did not land");

endmodule

//--- hw/console_power_pkg.sv
/*
  Constants shared by the console power interlock: clock rate, warm-up timing,
  register offsets, event bit positions and reset values.
  Assumes a single 40 MHz clock and a 32-bit register port with 4-bit byte addresses.
*/
package console_power_pkg;

  // Clock rate and period.
  localparam int unsigned CLK_FREQ_HZ    = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 25;

  // The warm-up delay is counted in slow ticks so that no counter runs past 32 bits.
  localparam int unsigned TICK_TIME_US   = 1000;
  localparam int unsigned TICK_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;
  localparam int unsigned WARM_TIME_MIN  = 5;
  localparam int unsigned WARM_TICKS     = (WARM_TIME_MIN * 60 * 1_000_000) / TICK_TIME_US;

  // Register map, byte addresses.
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  REG_EVENTS     = 4'h0;
  localparam logic [3:0]  REG_MASK       = 4'h4;
  localparam logic [3:0]  REG_STATE      = 4'h8;
  localparam logic [3:0]  REG_WARM       = 4'hc;

  // Event bits, shared by the event and mask registers.
  localparam int unsigned EV_STANDBY_ON  = 0;
  localparam int unsigned EV_STANDBY_OFF = 1;
  localparam int unsigned EV_HEAT_ON     = 2;
  localparam int unsigned EV_HEAT_OFF    = 3;
  localparam int unsigned EV_READY       = 4;
  localparam int unsigned EV_MAIN_ON     = 5;
  localparam int unsigned EV_MAIN_OFF    = 6;
  localparam int unsigned EV_OVERHEAT    = 7;
  localparam int unsigned EV_W           = 8;

  // State register bits.
  localparam int unsigned ST_STANDBY     = 0;
  localparam int unsigned ST_NEON        = 1;
  localparam int unsigned ST_CONTROL     = 2;
  localparam int unsigned ST_HEAT        = 3;
  localparam int unsigned ST_READY       = 4;
  localparam int unsigned ST_MAIN        = 5;
  localparam int unsigned ST_KEY         = 6;
  localparam int unsigned ST_W           = 7;

  // Values after reset.
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

endpackage

//--- tb/panel_operator.sv
/*
  Operator model for the console: presses one of the four pushbuttons on request,
  or holds any mix of them at a level chosen by the caller.
  Assumes the caller lets press return before asking for the next press.
*/
`timescale 1ns/1ps
module panel_operator (
  input  wire logic ref_clk,
  output logic      heat_enable_button,
  output logic      heat_disable_button,
  output logic      main_enable_button,
  output logic      main_disable_button
);
  logic [3:0] btn_q = 4'h0;

  assign heat_enable_button  = btn_q[0];
  assign heat_disable_button = btn_q[1];
  assign main_enable_button  = btn_q[2];
  assign main_disable_button = btn_q[3];

  // A press lasts two cycles, so the design must act on the edge and not the level.
  task automatic press(input int k);
    @(posedge ref_clk);
    btn_q <= 4'h1 << k;
    repeat (2) @(posedge ref_clk);
    btn_q <= 4'h0;
  endtask

  // The caller calls this right after a rising edge; the level stands until changed.
  task automatic hold(input logic [3:0] b);
    btn_q <= b;
  endtask
endmodule

//--- tb/test_console_power_interlock.sv
/*
  Self-checking bench for the console power interlock with short warm-up counts:
  directed cases, then a second reset and random panel traffic against a model.
  Assumes panel_operator drives the pushbuttons and the bench drives all else.
*/
`timescale 1ns/1ps
module test_console_power_interlock;
  logic        ref_clk, rstn, sw_up, sw_dn, overheat, ctl_pwr, key_on;
  logic        heat_en, heat_dis, main_en, main_dis, reg_wr, reg_rd, irq;
  logic        relay, neon, ctl_lamp, heat_pwr, heat_lamp, ready, main_pwr, main_lamp;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, m;
  logic [31:0] rnd_a, rnd_b, exp_rd;
  logic [7:0]  lamps;
  logic [5:0]  mdl, nx;
  logic [3:0]  bprev, btn;
  int          failures, checks, seed, age;

  localparam int TICKS  = 4;
  localparam int WTICKS = 5;
  localparam int WARM   = TICKS * WTICKS;

  assign lamps = {relay, neon, ctl_lamp, heat_pwr, heat_lamp, ready, main_pwr, main_lamp};

  console_power_interlock #(.TICK_CYCLES(TICKS), .WARM_TICKS(WTICKS))
    console_power_interlock_inst (
    .ref_clk(ref_clk), .rstn(rstn), .standby_switch_up(sw_up),
    .standby_switch_down(sw_dn), .tank_overheat(overheat),
    .control_power_present(ctl_pwr), .key_lock_on(key_on),
    .heat_enable_button(heat_en), .heat_disable_button(heat_dis),
    .main_enable_button(main_en), .main_disable_button(main_dis),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .standby_hold_relay(relay), .standby_neon(neon),
    .control_lamp(ctl_lamp), .heat_power_on(heat_pwr), .heat_lamp(heat_lamp),
    .ready_lamp(ready), .main_supply_on(main_pwr), .main_lamp(main_lamp));

  panel_operator panel_operator_inst (
    .ref_clk(ref_clk), .heat_enable_button(heat_en), .heat_disable_button(heat_dis),
    .main_enable_button(main_en), .main_disable_button(main_dis));

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  function automatic logic [7:0] pwr(input logic h, input logic r, input logic mn);
    return {3'h0, h, h, r, mn, mn};
  endfunction

  function automatic logic [31:0] bit_of(input int n);
    return 32'h1 << n;
  endfunction

  // Panel model: s = {standby, neon, control, heat, ready, main}; in = {up, down,
  // overheat, control power, key, presses of main-off, main-on, heat-off, heat-on}.
  function automatic logic [5:0] panel_next(input logic [5:0] s, input logic [8:0] in,
                                            input int age_now);
    logic sb, ht, mn;
    sb = in[7] ? 1'b0 : (in[8] | s[5]);
    ht = !in[1] && (s[2] || (in[0] && s[3]));
    mn = !in[1] && !in[3] && ht && (s[0] || (in[2] && in[4] && s[1]));
    return {sb, sb & ~in[6], in[5], ht, ht && s[2] && (age_now + 1 >= WARM), mn};
  endfunction

  function automatic logic [31:0] state_of(input logic [5:0] s, input logic key);
    return {25'h0, key, s[0], s[1], s[2], s[3], s[4], s[5]};
  endfunction

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic set_sw(input logic up, input logic dn, input logic oh);
    @(posedge ref_clk);
    sw_up    <= up;
    sw_dn    <= dn;
    overheat <= oh;
    step;
  endtask

  task automatic test_done;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    failures++;
    test_done;
  end

  initial begin
    seed = 32'h6268;
    {rstn, sw_up, sw_dn, overheat, ctl_pwr, key_on, reg_wr, reg_rd} <= 8'h00;
    reg_addr  <= 4'h0;
    reg_wdata <= 32'h0000_0000;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    step;
    set_sw(1'b1, 1'b0, 1'b0);
    chk_out({relay, neon}, 8'h03);
    set_sw(1'b0, 1'b0, 1'b0);
    chk_out({relay, neon}, 8'h03);
    set_sw(1'b0, 1'b0, 1'b1);
    chk_out({relay, neon}, 8'h02);
    set_sw(1'b0, 1'b1, 1'b0);
    chk_out({relay, neon}, 8'h00);
    set_sw(1'b0, 1'b0, 1'b0);
    panel_operator_inst.press(0);
    step;
    chk_out({ctl_lamp, heat_pwr}, 8'h00);
    @(posedge ref_clk);
    ctl_pwr <= 1'b1;
    key_on  <= 1'b1;
    step;
    chk_out(ctl_lamp, 8'h01);
    panel_operator_inst.press(0);
    step;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(1, 0, 0));
    panel_operator_inst.press(2);
    step;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(1, 0, 0));
    repeat (20) @(posedge ref_clk);
    #1;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(1, 1, 0));
    @(posedge ref_clk);
    key_on <= 1'b0;
    panel_operator_inst.press(2);
    step;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(1, 1, 0));
    @(posedge ref_clk);
    key_on <= 1'b1;
    panel_operator_inst.press(2);
    step;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(1, 1, 1));
    panel_operator_inst.press(3);
    step;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(1, 1, 0));
    panel_operator_inst.press(2);
    panel_operator_inst.press(1);
    step;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(0, 0, 0));
    panel_operator_inst.press(0);
    repeat (8) @(posedge ref_clk);
    #1;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(1, 0, 0));
    repeat (20) @(posedge ref_clk);
    #1;
    chk_out({heat_pwr, heat_lamp, ready, main_pwr, main_lamp}, pwr(1, 1, 0));
    rd(4'h0, v);
    wr(4'h4, bit_of(console_power_pkg::EV_STANDBY_ON));
    set_sw(1'b1, 1'b0, 1'b0);
    set_sw(1'b0, 1'b0, 1'b0);
    chk_out(irq, 8'h01);
    rd(4'h0, v);
    chk_rd(v, bit_of(console_power_pkg::EV_STANDBY_ON));
    step;
    chk_out(irq, 8'h00);
    wr(4'h4, 32'h0000_0000);
    set_sw(1'b0, 1'b1, 1'b0);
    chk_out(irq, 8'h00);
    rd(4'h0, v);
    chk_rd(v, bit_of(console_power_pkg::EV_STANDBY_OFF));
    rd(4'h2, v);
    chk_rd(v, 32'h0000_0000);
    rd(4'h8, v);
    chk_rd(v, bit_of(2) | bit_of(3) | bit_of(4) | bit_of(6));
    for (int i = 0; i < 4; i++) begin
      m = $random(seed);
      wr(4'h4, m);
      rd(4'h4, v);
      chk_rd(v, {24'h00_0000, m[7:0]});
    end
    // A second reset in mid-run, then random panel traffic against the model.
    @(posedge ref_clk);
    rstn <= 1'b0;
    {sw_up, sw_dn, overheat, ctl_pwr, key_on, reg_rd} <= 6'h00;
    panel_operator_inst.hold(4'h0);
    #1;
    chk_out(lamps, 8'h00);
    chk_out(irq, 8'h00);
    chk_rd(reg_rdata, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    mdl   = 6'h00;
    bprev = 4'h0;
    age   = 0;
    for (int i = 0; i < 500; i++) begin
      @(posedge ref_clk);
      btn    = {main_dis, main_en, heat_dis, heat_en};
      exp_rd = 32'h0000_0000;
      if (reg_rd && reg_addr == console_power_pkg::REG_STATE) begin
        exp_rd = state_of(mdl, key_on);
      end
      nx    = panel_next(mdl, {sw_up, sw_dn, overheat, ctl_pwr, key_on, btn & ~bprev}, age);
      age   = (mdl[2] && nx[2]) ? age + 1 : 0;
      mdl   = nx;
      bprev = btn;
      rnd_a = $random(seed);
      rnd_b = $random(seed);
      sw_up    <= &rnd_a[2:0];
      sw_dn    <= &rnd_a[6:3];
      overheat <= &rnd_a[9:7];
      ctl_pwr  <= |rnd_a[12:10];
      key_on   <= |rnd_a[14:13];
      reg_rd   <= rnd_b[14];
      reg_addr <= rnd_b[15] ? console_power_pkg::REG_STATE : {rnd_b[17:16], 2'b11};
      panel_operator_inst.hold({&rnd_b[4:0], &rnd_b[6:5], &rnd_b[11:7], &rnd_b[13:12]});
      #1;
      chk_out(lamps, {mdl[5:2], mdl[2:1], mdl[0], mdl[0]});
      chk_rd(reg_rdata, exp_rd);
      chk_out(irq, 8'h00);
    end
    reg_rd <= 1'b0;
    test_done;
  end
endmodule
